// ===== verilog/pafs_regs.svh
`ifndef PAFS_REGS_SVH
`define PAFS_REGS_SVH

// Serial addresses of the registers held here
`define PAFS_ADDR_CFG0   8'h04
`define PAFS_ADDR_CFG1   8'h05
`define PAFS_ADDR_SLOPE  8'h19
`define PAFS_ADDR_BLOCK  8'h1A
`define PAFS_ADDR_STAGE  8'h1B
`define PAFS_ADDR_ANT    8'h1F

// Storage slots
`define PAFS_NREG        6
`define PAFS_IDX_CFG0    3'h0
`define PAFS_IDX_CFG1    3'h1
`define PAFS_IDX_SLOPE   3'h2
`define PAFS_IDX_BLOCK   3'h3
`define PAFS_IDX_STAGE   3'h4
`define PAFS_IDX_ANT     3'h5
`define PAFS_IDX_NONE    3'h7

// Reset values
`define PAFS_RST_CFG0    8'h06
`define PAFS_RST_CFG1    8'h25
`define PAFS_RST_SLOPE   8'h80
`define PAFS_RST_BLOCK   8'h00
`define PAFS_RST_STAGE   8'h00
`define PAFS_RST_ANT     8'h20

// Field positions
`define PAFS_DISARM_BIT  4
`define PAFS_BAND_LSB    2
`define PAFS_RAMP_BIT    4
`define PAFS_MOD1_BIT    5
`define PAFS_MOD2_BIT    6
`define PAFS_DUTYOFF_BIT 6
`define PAFS_DUTY_LSB    4
`define PAFS_BLK1_LSB    2
`define PAFS_BLK2_LSB    5

// Band code of the 315 MHz band, fixed stage limit
`define PAFS_BAND_315    2'h1
`define PAFS_MAX_STAGES  4'hB

// Error flag positions
`define PAFS_FLAG_LOCK   0
`define PAFS_FLAG_PAR    1
`define PAFS_FLAG_BROWN  2

`endif

// ===== verilog/pafs_pkg.sv
`include "pafs_regs.svh"

package pafs_pkg;

    // Amplifier duty-cycle selection
    typedef enum logic [2:0] {
        DUTY_NONE, DUTY_33, DUTY_43, DUTY_39, DUTY_35, DUTY_31
    } pafs_duty_t;

    // Serial receiver state
    typedef struct packed {
        logic [15:0] shift;
        logic [4:0]  bits;
        logic        done;
    } pafs_spi_t;

    // Stage ramp state
    typedef struct packed {
        logic [9:0] cnt;
        logic [3:0] level;
    } pafs_ramp_t;

    // Core state on the reference clock
    typedef struct packed {
        logic [`PAFS_NREG-1:0][7:0] regs;
        logic [`PAFS_NREG-1:0]      par;
        logic [2:0]                 doneSync;
        logic [1:0]                 bodSync;
        logic [1:0]                 lockSync;
        logic [2:0]                 flags;
        logic                       paEn;
        logic [10:0]                stageOn;
        logic [2:0]                 blockOn;
        logic [3:0]                 capOn;
        pafs_duty_t                 duty;
    } pafs_core_t;

endpackage : pafs_pkg

// ===== verilog/pafs_spi_rx.sv
`timescale 1ns/1ps
// Serial write receiver on the bus clock; frame reset by enable low
module pafs_spi_rx (
    input  wire logic       spiClk,   // Bus clock
    input  wire logic       spiEn,    // Frame enable
    input  wire logic       spiData,  // Serial data in
    input  wire logic       rst_b,    // Chip reset
    output logic [7:0]      addr,     // Captured address
    output logic [7:0]      data,     // Captured data
    output logic            done      // Level: 16 bits taken
);
    import pafs_pkg::*;

    pafs_spi_t st;       // Receiver state
    pafs_spi_t next_st;  // Next receiver state
    logic      frameRst_b;

    // Frame end clears the receiver, since the bus clock stops between frames
    assign frameRst_b = rst_b & spiEn;

    // Shift MSB first, freeze after 16 bits so the core reads stable words
    always_comb begin
        next_st = st;
        if (!st.done) begin
            next_st.shift = {st.shift[14:0], spiData};
            next_st.bits  = st.bits + 5'h01;
            next_st.done  = (st.bits == 5'h0F);
        end
    end

    // State register
    always_ff @(posedge spiClk or negedge frameRst_b) begin
        if (!frameRst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign addr = st.shift[15:8];
    assign data = st.shift[7:0];
    assign done = st.done;

endmodule : pafs_spi_rx

// ===== verilog/pafs_slope_ramp.sv
`timescale 1ns/1ps
// Steps the active stage count toward its target
module pafs_slope_ramp #(
    parameter int DIV_W = 10  // Divider width
) (
    input  wire logic             ref_clk,  // Reference clock
    input  wire logic             rst_b,    // Async reset
    input  wire logic [3:0]       target,   // Wanted stage count
    input  wire logic [DIV_W-1:0] divider,  // Code; ratio is code plus one
    input  wire logic             rampOn,   // Timed stepping enabled
    output logic [3:0]            level     // Stages now on
);
    import pafs_pkg::*;

    if (DIV_W != 10) begin : gDivCheck
        $error("pafs_slope_ramp: divider width must be 10");
    end

    pafs_ramp_t st;       // Ramp state
    pafs_ramp_t next_st;  // Next ramp state

    // One stage per divider period, or a jump when stepping is off
    always_comb begin
        next_st = st;
        if (st.level == target) begin
            next_st.cnt = '0;
        end else if (!rampOn) begin
            next_st.level = target; // R16
            next_st.cnt   = '0;
        end else if (st.cnt == divider) begin
            // Period of divider+1 cycles gives ratio 1 for code 0
            next_st.level = (st.level < target) ? st.level + 4'h1 : st.level - 4'h1; // R9
            next_st.cnt   = '0;
        end else begin
            next_st.cnt = st.cnt + 10'h001; // R9
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level = st.level;

    // Level holds while the divider count runs
    step_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R9
        (rampOn && st.level != target && st.cnt != divider) |=> $stable(st.level))
        else $error("stage changed before divider elapsed");

endmodule : pafs_slope_ramp

// ===== verilog/pafs_control.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: 315 MHz band forces fixed 33 percent duty
// R2: Four tuning switches, one bit each
// R3: Bits 0..3 map 60/120/240/480 fF
// R4: Disarm bit resets to zero, armed
// R5: Software disarms with 1, re-arms with 0
// R6: Armed errors switch amplifier drivers off
// R7: Disarmed errors flag but keep transmitting
// R8: Ten-bit divider split over two registers
// R9: Divider cycles between successive stage steps
// R10: Three block enables per power setting
// R11: Stage count clamps above eleven
// R12: Zero stage count leaves amplifier off; code drops only the stage switches, paEnable and block enables stay on
// R13: Command picks power and modulation pair
// R14: Duty disable bit: 0 delay, 1 none
// R15: Delay code picks 43/39/35/31 percent
// R16: Without ramp all stages switch together
`include "pafs_regs.svh"
module pafs_control (
    input  wire logic          ref_clk,         // Reference clock
    input  wire logic          rst_b,           // Async reset
    input  wire logic          spiClk,          // Serial bus clock
    input  wire logic          spiEn,           // Serial frame enable
    input  wire logic          spiData,         // Serial data in
    input  wire logic          txActive,        // Transmission in progress
    input  wire logic          txSetSel,        // 0 setting 1, 1 setting 2
    input  wire logic          txData,          // Modulation data bit
    input  wire logic          brownoutDetect,  // Brownout detector, async
    input  wire logic          lockLost,        // Lock detector fail, async
    input  wire logic          parityFault,     // Fault injection into parity
    input  wire logic          clearFlags,      // Status read pulse
    output logic [2:0]         errFlags,        // Sticky lock/parity/brownout
    output logic               paEnable,        // Amplifier drivers on
    output logic [10:0]        paStageOn,       // Stage switches
    output logic [2:0]         paBlockOn,       // Block enables
    output logic [3:0]         antennaCapOn,    // Tuning capacitor switches
    output pafs_pkg::pafs_duty_t dutySel        // Duty-cycle choice
);
    import pafs_pkg::*;

    pafs_core_t st;       // Core state
    pafs_core_t next_st;  // Next core state

    logic [7:0]            spiAddr;     // Address from receiver
    logic [7:0]            spiWrData;   // Data from receiver
    logic                  spiDone;     // Receiver done level
    logic [2:0]            wrIdx;       // Decoded slot
    logic                  wrEvt;       // One-cycle write strobe
    logic [`PAFS_NREG-1:0] parErr;      // Per-slot parity mismatch
    logic                  disarm;      // Cut-off disarmed
    logic                  kill;        // Cut-off active
    logic                  fskMode;     // Selected modulation is FSK
    logic [3:0]            rawCount;    // Selected stage code
    logic [3:0]            stageCount;  // Clamped stage count
    logic [2:0]            selBlocks;   // Selected block enables
    logic [3:0]            target;      // Ramp target
    logic [3:0]            rampLevel;   // Stages now on
    logic [9:0]            divider;     // Ramp divider code
    logic [10:0]           thermo;      // Level as stage mask
    logic [1:0]            band;        // Band select field

    // Serial receiver on the bus clock
    pafs_spi_rx uSpi (
        .spiClk (spiClk),
        .spiEn  (spiEn),
        .spiData(spiData),
        .rst_b  (rst_b),
        .addr   (spiAddr),
        .data   (spiWrData),
        .done   (spiDone)
    );

    // Done level is synchronised; words stay frozen until frame end
    assign wrEvt = st.doneSync[1] & ~st.doneSync[2];

    // Address decode; unmapped and read-only addresses are ignored
    always_comb begin
        case (spiAddr)
            `PAFS_ADDR_CFG0:  wrIdx = `PAFS_IDX_CFG0;
            `PAFS_ADDR_CFG1:  wrIdx = `PAFS_IDX_CFG1;
            `PAFS_ADDR_SLOPE: wrIdx = `PAFS_IDX_SLOPE;
            `PAFS_ADDR_BLOCK: wrIdx = `PAFS_IDX_BLOCK;
            `PAFS_ADDR_STAGE: wrIdx = `PAFS_IDX_STAGE;
            `PAFS_ADDR_ANT:   wrIdx = `PAFS_IDX_ANT;
            default:          wrIdx = `PAFS_IDX_NONE;
        endcase
    end

    // Continuous parity check of every held register
    for (genvar i = 0; i < `PAFS_NREG; i++) begin : gPar
        assign parErr[i] = ^{st.regs[i], st.par[i]};
    end

    // Field extraction for the selected setting pair
    assign disarm   = st.regs[`PAFS_IDX_CFG0][`PAFS_DISARM_BIT];
    assign band     = st.regs[`PAFS_IDX_CFG0][`PAFS_BAND_LSB +: 2];
    assign kill     = ~disarm & (|st.flags); // R6 R7
    assign fskMode  = txSetSel ? st.regs[`PAFS_IDX_CFG1][`PAFS_MOD2_BIT]
                               : st.regs[`PAFS_IDX_CFG1][`PAFS_MOD1_BIT]; // R13
    assign rawCount = txSetSel ? st.regs[`PAFS_IDX_STAGE][7:4]
                               : st.regs[`PAFS_IDX_STAGE][3:0]; // R13
    assign selBlocks = txSetSel ? st.regs[`PAFS_IDX_BLOCK][`PAFS_BLK2_LSB +: 3]
                                : st.regs[`PAFS_IDX_BLOCK][`PAFS_BLK1_LSB +: 3]; // R10
    // Codes above eleven act as eleven
    assign stageCount = (rawCount > `PAFS_MAX_STAGES) ? `PAFS_MAX_STAGES : rawCount; // R11
    // Upper two bits live beside the block enables
    assign divider = {st.regs[`PAFS_IDX_BLOCK][1:0], st.regs[`PAFS_IDX_SLOPE]}; // R8

    // FSK holds the counted stages on; ASK follows data; a cut-off drops all
    always_comb begin
        if (!txActive || kill) begin
            target = 4'h0; // R6
        end else if (fskMode || txData) begin
            target = stageCount; // R12
        end else begin
            target = 4'h0;
        end
    end

    // Stage stepping
    pafs_slope_ramp #(.DIV_W(10)) uRamp (
        .ref_clk(ref_clk),
        .rst_b  (rst_b),
        .target (target),
        .divider(divider),
        .rampOn (st.regs[`PAFS_IDX_CFG1][`PAFS_RAMP_BIT] & ~fskMode & ~kill), // R16
        .level  (rampLevel)
    );

    // Stage n is on while the ramp level is above n
    for (genvar i = 0; i < 11; i++) begin : gStage
        assign thermo[i] = (rampLevel > 4'(i));
    end

    // Next-state logic of the core
    always_comb begin
        next_st          = st;
        next_st.doneSync = {st.doneSync[1:0], spiDone};
        next_st.bodSync  = {st.bodSync[0], brownoutDetect};
        next_st.lockSync = {st.lockSync[0], lockLost};
        // Register writes keep their parity bit alongside
        if (wrEvt && wrIdx != `PAFS_IDX_NONE) begin
            next_st.regs[wrIdx] = spiWrData; // R5
            next_st.par[wrIdx]  = ^spiWrData;
        end
        if (parityFault) begin
            next_st.par[`PAFS_IDX_CFG0] = ~st.par[`PAFS_IDX_CFG0];
        end
        // Clear first, so an error in the clear cycle still lands
        if (clearFlags) begin
            next_st.flags = 3'h0;
        end
        if (st.bodSync[1]) begin
            next_st.flags[`PAFS_FLAG_BROWN] = 1'b1; // R7
        end
        if (|parErr) begin
            next_st.flags[`PAFS_FLAG_PAR] = 1'b1; // R7
        end
        if (st.lockSync[1] && txActive) begin
            next_st.flags[`PAFS_FLAG_LOCK] = 1'b1; // R7
        end
        // Disarmed: errors never stop a running transmission
        next_st.paEn    = txActive & ~kill; // R6 R7
        // Zero count drops every stage at once, even in the middle of a ramp
        next_st.stageOn = (kill || stageCount == 4'h0) ? 11'h000 : thermo; // R6 R12
        next_st.blockOn = (txActive && !kill) ? selBlocks : 3'h0; // R10
        next_st.capOn   = st.regs[`PAFS_IDX_ANT][3:0]; // R2 R3
        // Duty choice: band override, then disable, then code
        if (band == `PAFS_BAND_315) begin
            next_st.duty = DUTY_33; // R1
        end else if (band == 2'h0 || st.regs[`PAFS_IDX_ANT][`PAFS_DUTYOFF_BIT]) begin
            next_st.duty = DUTY_NONE; // R14 R15
        end else begin
            case (st.regs[`PAFS_IDX_ANT][`PAFS_DUTY_LSB +: 2])
                2'h0:    next_st.duty = DUTY_43; // R15
                2'h1:    next_st.duty = DUTY_39;
                2'h2:    next_st.duty = DUTY_35;
                default: next_st.duty = DUTY_31;
            endcase
        end
    end

    // Core register; reset values loaded as constants
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st                       <= '0;
            st.regs[`PAFS_IDX_CFG0]  <= `PAFS_RST_CFG0; // R4
            st.regs[`PAFS_IDX_CFG1]  <= `PAFS_RST_CFG1;
            st.regs[`PAFS_IDX_SLOPE] <= `PAFS_RST_SLOPE;
            st.regs[`PAFS_IDX_BLOCK] <= `PAFS_RST_BLOCK;
            st.regs[`PAFS_IDX_STAGE] <= `PAFS_RST_STAGE;
            st.regs[`PAFS_IDX_ANT]   <= `PAFS_RST_ANT;
            st.par[`PAFS_IDX_CFG0]   <= ^`PAFS_RST_CFG0;
            st.par[`PAFS_IDX_CFG1]   <= ^`PAFS_RST_CFG1;
            st.par[`PAFS_IDX_SLOPE]  <= ^`PAFS_RST_SLOPE;
            st.par[`PAFS_IDX_ANT]    <= ^`PAFS_RST_ANT;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state
    assign errFlags     = st.flags;
    assign paEnable     = st.paEn;
    assign paStageOn    = st.stageOn;
    assign paBlockOn    = st.blockOn;
    assign antennaCapOn = st.capOn;
    assign dutySel      = st.duty;

    // Helper: any write to config register CFG0 seen since reset
    logic cfgWritten;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfgWritten <= 1'b0;
        end else if (wrEvt && wrIdx == `PAFS_IDX_CFG0) begin
            cfgWritten <= 1'b1;
        end
    end

    // Steady transmit with stages wanted for three cycles
    sequence seqSteadyFull;
        (txActive && fskMode && !kill && stageCount == 4'hB) [*3];
    endsequence

    sequence seqSteadyZero;
        (stageCount == 4'h0) [*3];
    endsequence

    disarm_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R4
        !cfgWritten |-> !disarm)
        else $error("cut-off not armed out of reset");

    disarm_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R5
        $changed(disarm) |-> $past(wrEvt && wrIdx == `PAFS_IDX_CFG0))
        else $error("disarm bit moved without a write");

    failsafe_kill_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R6
        (!disarm && |st.flags) |=> (!paEnable && paStageOn == 11'h000))
        else $error("amplifier left on after armed error");

    disarmed_tx_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R7
        (disarm && txActive) |=> paEnable)
        else $error("disarmed error stopped transmission");

    brownout_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R7
        st.bodSync[1] |=> errFlags[`PAFS_FLAG_BROWN])
        else $error("brownout flag not set");

    stage_full_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R11
        seqSteadyFull |-> (paStageOn == 11'h7FF))
        else $error("clamped stage count not all on");

    zero_count_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R12
        seqSteadyZero |-> (paStageOn == 11'h000))
        else $error("stages on with zero count");

    tune_map_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R3
        (wrEvt && wrIdx == `PAFS_IDX_ANT) |-> ##2 (antennaCapOn == $past(spiWrData[3:0], 2)))
        else $error("tuning switch mismatch");

    duty_band_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R1
        (band == `PAFS_BAND_315) |=> (dutySel == DUTY_33))
        else $error("315 band duty not forced");

    duty_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R15
        (band == 2'h0) |=> (dutySel == DUTY_NONE))
        else $error("band zero duty delay not zero");

    // Flags latch one edge after their cause: synchronised lock loss during transmission, or a parity mismatch
    lock_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R6
        (st.lockSync[1] && txActive) |=> errFlags[`PAFS_FLAG_LOCK])
        else $error("lock flag not set");

    parity_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R6
        (|parErr) |=> errFlags[`PAFS_FLAG_PAR])
        else $error("parity flag not set");

    brown_sticky_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R7
        (errFlags[`PAFS_FLAG_BROWN] && !clearFlags) |=> errFlags[`PAFS_FLAG_BROWN])
        else $error("brownout flag lost without a clear");

    // Cut-off also drops the block enables
    cut_blocks_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R6
        (!disarm && |st.flags) |=> (paBlockOn == 3'h0))
        else $error("blocks left on after armed error");

    block_select_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R10
        (txActive && !kill) |=> (paBlockOn == $past(selBlocks)))
        else $error("block enables not those of the selected setting");

    tx_end_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R7
        !txActive |=> !paEnable)
        else $error("amplifier on outside a transmission");

    zero_stage_off_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R12
        (stageCount == 4'h0) |=> (paStageOn == 11'h000))
        else $error("stages on one edge after zero count");

    // Ramp bit low: the level lands on the target in one edge
    ramp_off_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R16
        (!st.regs[`PAFS_IDX_CFG1][`PAFS_RAMP_BIT] && rampLevel != target)
        |=> (rampLevel == $past(target)))
        else $error("stages stepped with ramp disabled");

    duty_code_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R15
        (band != `PAFS_BAND_315 && band != 2'h0
         && !st.regs[`PAFS_IDX_ANT][`PAFS_DUTYOFF_BIT]
         && st.regs[`PAFS_IDX_ANT][`PAFS_DUTY_LSB +: 2] == 2'h0) |=> (dutySel == DUTY_43))
        else $error("delay code zero not 43 percent");

    duty_off_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R14
        (band != `PAFS_BAND_315 && st.regs[`PAFS_IDX_ANT][`PAFS_DUTYOFF_BIT])
        |=> (dutySel == DUTY_NONE))
        else $error("duty disable bit ignored");

endmodule : pafs_control

// ===== tb/pafs_host_model.sv
`timescale 1ns/1ps
// Host side of the serial configuration bus; writes only
module pafs_host_model (
    output logic spiClk,  // Bus clock, runs only inside frames
    output logic spiEn,   // Frame enable
    output logic spiData  // Serial data, MSB first
);
    // Idle bus at time zero
    initial begin
        spiClk  = 1'b0;
        spiEn   = 1'b0;
        spiData = 1'b0;
    end

    // One 16-bit write frame at a 64 ns bus period
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        logic [15:0] frame;
        frame = {addr, data};
        spiEn = 1'b1;
        #37.3;
        for (int i = 15; i >= 0; i--) begin
            // Data changes while the clock is low
            spiData = frame[i];
            #32 spiClk = 1'b1;
            #32 spiClk = 1'b0;
        end
        // Enable stays high well past the sync latency
        #44 spiEn = 1'b0;
        // Released line shows no stale bit
        spiData = ~spiData;
        #71;
    endtask : write_reg
endmodule : pafs_host_model

// ===== tb/pafs_control_tb_top.sv
`timescale 1ns/1ps
`include "pafs_regs.svh"
module pafs_control_tb_top;
    import pafs_pkg::*;
    logic        ref_clk        = 1'b0;  // 250 MHz
    logic        rst_b          = 1'b0;  // Async reset
    logic        txActive       = 1'b0;  // Transmit level
    logic        txSetSel       = 1'b0;  // Setting pair choice
    logic        txData         = 1'b0;  // ASK data
    logic        brownoutDetect = 1'b0;  // Fault sources
    logic        lockLost       = 1'b0;
    logic        parityFault    = 1'b0;
    logic        clearFlags     = 1'b0;  // Status read pulse
    logic        spiClk;                 // Bus from host model
    logic        spiEn;
    logic        spiData;
    logic [2:0]  errFlags;               // Design outputs
    logic        paEnable;
    logic [10:0] paStageOn;
    logic [2:0]  paBlockOn;
    logic [3:0]  antennaCapOn;
    pafs_duty_t  dutySel;
    pafs_duty_t  dutyTab [4] = '{DUTY_43, DUTY_39, DUTY_35, DUTY_31};  // Per delay code
    int          fail_count = 0;
    int          tests_run  = 0;

    // Reference clock
    always #2 ref_clk = ~ref_clk;

    pafs_host_model i_pafs_host_model (.spiClk(spiClk), .spiEn(spiEn), .spiData(spiData));

    pafs_control i_pafs_control (
        .ref_clk(ref_clk), .rst_b(rst_b), .spiClk(spiClk), .spiEn(spiEn),
        .spiData(spiData), .txActive(txActive), .txSetSel(txSetSel), .txData(txData),
        .brownoutDetect(brownoutDetect), .lockLost(lockLost), .parityFault(parityFault),
        .clearFlags(clearFlags), .errFlags(errFlags), .paEnable(paEnable),
        .paStageOn(paStageOn), .paBlockOn(paBlockOn), .antennaCapOn(antennaCapOn),
        .dutySel(dutySel)
    );

    // Cycles, always landing just after a rising edge
    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : cyc

    task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task report_and_stop;
        if (fail_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    // Register write, then wait out sync and output stages
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_pafs_host_model.write_reg(a, d);
        cyc(8);
    endtask : wr

    task automatic clear_flags;
        clearFlags = 1'b1;
        cyc(1);
        clearFlags = 1'b0;
        cyc(2);
    endtask : clear_flags

    // Bounded wait for a stage pattern; a hang ends the run
    task automatic wait_stage(input logic [10:0] pat, output int c);
        c = 0;
        while (paStageOn !== pat && c < 2000) begin
            cyc(1);
            c++;
        end
        if (c >= 2000) begin
            fail_count++;
            report_and_stop();
        end
    endtask : wait_stage

    // Gap between first and second stage switching on
    task automatic step_gap(input logic [10:0] exp);
        int c;
        wait_stage(11'h001, c);
        wait_stage(11'h003, c);
        chk("stepGap", exp, 11'(c));
        txData = 1'b0;
        wait_stage(11'h000, c);
    endtask : step_gap

    initial begin
        cyc(4);
        rst_b = 1'b1;
        cyc(2);
        chk("dutyReset", 11'(DUTY_33), 11'(dutySel));
        chk("capReset", 11'h000, 11'(antennaCapOn));
        // FSK setting 1 by default: amplifier on while transmitting
        txActive = 1'b1;
        cyc(3);
        chk("paOn", 11'h001, 11'(paEnable));
        // Armed from reset: lock and brownout cut the drivers
        for (int n = 0; n < 2; n++) begin
            lockLost = (n == 0);
            brownoutDetect = (n == 1);
            cyc(8);
            chk("errFlags", 11'(3'b001 << (2 * n)), 11'(errFlags));
            chk("paCut", 11'h000, 11'(paEnable));
            lockLost = 1'b0;
            brownoutDetect = 1'b0;
            cyc(4);
            clear_flags();
            chk("errClear", 11'h000, 11'(errFlags));
            chk("paBack", 11'h001, 11'(paEnable));
        end
        // Parity upset stays until the register is rewritten
        parityFault = 1'b1;
        cyc(1);
        parityFault = 1'b0;
        cyc(6);
        chk("parFlag", 11'h002, 11'(errFlags));
        chk("parCut", 11'h000, 11'(paEnable));
        wr(`PAFS_ADDR_CFG0, 8'h08);
        clear_flags();
        chk("parClear", 11'h000, 11'(errFlags));
        // Disarmed: flag set, amplifier keeps going; re-arm cuts it
        wr(`PAFS_ADDR_CFG0, 8'h18);
        brownoutDetect = 1'b1;
        cyc(8);
        brownoutDetect = 1'b0;
        chk("disFlag", 11'h004, 11'(errFlags));
        chk("disPa", 11'h001, 11'(paEnable));
        wr(`PAFS_ADDR_CFG0, 8'h08);
        chk("rearmCut", 11'h000, 11'(paEnable));
        clear_flags();
        chk("rearmBack", 11'h001, 11'(paEnable));
        // Delay codes and one capacitor per bit
        for (int n = 0; n < 4; n++) begin
            wr(`PAFS_ADDR_ANT, 8'((n << 4) | (1 << n)));
            chk("capBit", 11'(1 << n), 11'(antennaCapOn));
            chk("dutyCode", 11'(dutyTab[n]), 11'(dutySel));
        end
        wr(`PAFS_ADDR_ANT, 8'h4F);
        chk("dutyOff", 11'(DUTY_NONE), 11'(dutySel));
        chk("capAll", 11'h00F, 11'(antennaCapOn));
        wr(`PAFS_ADDR_CFG0, 8'h04);
        chk("duty315", 11'(DUTY_33), 11'(dutySel));
        wr(`PAFS_ADDR_ANT, 8'h30);
        wr(`PAFS_ADDR_CFG0, 8'h00);
        chk("dutyBand0", 11'(DUTY_NONE), 11'(dutySel));
        // Unmapped address leaves the tuning bits alone
        wr(8'h20, 8'hFF);
        chk("unmapped", 11'h000, 11'(antennaCapOn));
        // Two power settings, FSK, ramp off
        wr(`PAFS_ADDR_BLOCK, 8'h54);
        wr(`PAFS_ADDR_STAGE, 8'hF3);
        wr(`PAFS_ADDR_CFG1, 8'h60);
        chk("stages1", 11'h007, paStageOn);
        chk("blocks1", 11'h005, 11'(paBlockOn));
        txSetSel = 1'b1;
        cyc(4);
        chk("stages2", 11'h7FF, paStageOn);
        chk("blocks2", 11'h002, 11'(paBlockOn));
        txSetSel = 1'b0;
        wr(`PAFS_ADDR_STAGE, 8'hF0);
        chk("stagesZero", 11'h000, paStageOn);
        // ASK without ramp: all stages at once
        wr(`PAFS_ADDR_STAGE, 8'h03);
        wr(`PAFS_ADDR_CFG1, 8'h00);
        txData = 1'b1;
        cyc(3);
        chk("askFlat", 11'h007, paStageOn);
        txData = 1'b0;
        cyc(3);
        chk("askOff", 11'h000, paStageOn);
        // ASK with ramp: divider code plus one cycles per step
        wr(`PAFS_ADDR_CFG1, 8'h10);
        wr(`PAFS_ADDR_SLOPE, 8'h03);
        txData = 1'b1;
        step_gap(11'd4);
        wr(`PAFS_ADDR_BLOCK, 8'h55);
        wr(`PAFS_ADDR_SLOPE, 8'h00);
        txData = 1'b1;
        step_gap(11'd257);
        report_and_stop();
    end
endmodule : pafs_control_tb_top
